// ### bench/cpsc_host_model.sv
`timescale 1ns/100ps
module cpsc_host_model (
  // Serial link to switch
  output logic ser_data,
  output logic ser_clk,
  output logic ser_latch
);
  initial begin
    ser_data = 1'b0;
    ser_clk = 1'b0;
    ser_latch = 1'b0;
  end
  // Link clock idles low between frames
  task automatic send(input logic [10:0] w);
    for (int i = 10; i >= 0; i--) begin
      ser_data = w[i];
      #200 ser_clk = 1'b1;
      #200 ser_clk = 1'b0;
    end
    ser_data = ~w[0];
    #100 ser_latch = 1'b1;
    #300 ser_latch = 1'b0;
  endtask
endmodule

// ### bench/test_card_power_switch_serial_ctrl.sv
`timescale 1ns/100ps
module test_card_power_switch_serial_ctrl;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic card_reset = 1'b0;
  logic card_reset_n = 1'b1;
  logic mode_indep = 1'b0;
  logic [3:0] overcurrent = 4'h0;
  logic overtemp = 1'b0;
  logic ser_data, ser_clk, ser_latch, fault_flag_n;
  cpsc_pkg::cpsc_sel_t ca, cb, pa, pb;
  int mismatches = 0;
  int cmp_count = 0;
  cpsc_ctrl i_cpsc_ctrl (.clk(clk), .rst_n(rst_n), .ser_data(ser_data), .ser_clk(ser_clk), .ser_latch(ser_latch),
    .card_reset(card_reset), .card_reset_n(card_reset_n), .mode_indep(mode_indep), .overcurrent(overcurrent),
    .overtemp(overtemp), .slot_a_card_supply(ca), .slot_b_card_supply(cb), .slot_a_prog_supply(pa),
    .slot_b_prog_supply(pb), .fault_flag_n(fault_flag_n));
  cpsc_host_model i_cpsc_host_model (.ser_data(ser_data), .ser_clk(ser_clk), .ser_latch(ser_latch));
  always #25 clk = ~clk;
  task automatic cmp_sel(input cpsc_pkg::cpsc_sel_t got, input cpsc_pkg::cpsc_sel_t exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Expected selection of output k: 0/1 card A/B, 2/3 prog A/B
  function automatic cpsc_pkg::cpsc_sel_t exp_sel(input logic [10:0] w, input int k, input logic g);
    logic [1:0] v;
    logic [1:0] p;
    cpsc_pkg::cpsc_sel_t vs;
    v = k[0] ? {w[6], w[7]} : {w[3], w[2]};
    p = k[0] ? {w[4], w[5]} : {w[0], w[1]};
    vs = v == 2'h1 ? cpsc_pkg::CPSC_V33 : v == 2'h2 ? cpsc_pkg::CPSC_V5 : cpsc_pkg::CPSC_ZERO;
    if (g) return cpsc_pkg::CPSC_GND;
    if (!w[8]) return cpsc_pkg::CPSC_HIZ;
    if (k < 2) return vs;
    case (p)
      2'h0: return cpsc_pkg::CPSC_ZERO;
      2'h1: return !mode_indep ? vs : (k[0] ? w[10] : w[9]) ? cpsc_pkg::CPSC_V5 : cpsc_pkg::CPSC_V33;
      2'h2: return cpsc_pkg::CPSC_V12;
      default: return cpsc_pkg::CPSC_HIZ;
    endcase
  endfunction
  task automatic chk(input logic [10:0] w, input logic g);
    cmp_sel(ca, exp_sel(w, 0, g));
    cmp_sel(cb, exp_sel(w, 1, g));
    cmp_sel(pa, exp_sel(w, 2, g));
    cmp_sel(pb, exp_sel(w, 3, g));
  endtask
  task automatic load(input logic [10:0] w);
    i_cpsc_host_model.send(w);
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic t_power_up();
    chk(11'h000, 1'b1);
    cmp_bit(fault_flag_n, 1'b1);
    $display("test power_up done");
  endtask
  task automatic t_decode();
    logic [10:0] w;
    for (int m = 0; m < 2; m++) begin
      mode_indep = m[0];
      for (int i = 0; i < 32; i++) begin
        w = {i[4], ~i[4], 1'b1, ~i[3:0], i[3:0]};
        load(w);
        chk(w, 1'b0);
      end
    end
    $display("test decode done");
  endtask
  task automatic t_shutdown();
    load(11'h0AF);
    chk(11'h0AF, 1'b0);
    $display("test shutdown done");
  endtask
  task automatic t_reset_pins();
    for (int k = 0; k < 2; k++) begin
      card_reset = (k == 0);
      card_reset_n = (k == 0);
      repeat (5) @(posedge clk);
      #1;
      chk(11'h000, 1'b1);
      load(11'h12A);
      chk(11'h000, 1'b1);
      card_reset = 1'b0;
      card_reset_n = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      chk(11'h000, 1'b1);
      load(11'h12A);
      chk(11'h12A, 1'b0);
    end
    $display("test reset_pins done");
  endtask
  task automatic t_fault();
    for (int i = 0; i < 5; i++) begin
      overcurrent = 4'h1 << i;
      overtemp = (i == 4);
      repeat (5) @(posedge clk);
      #1;
      cmp_bit(fault_flag_n, 1'b0);
      overcurrent = 4'h0;
      overtemp = 1'b0;
      repeat (5) @(posedge clk);
      #1;
      cmp_bit(fault_flag_n, 1'b1);
    end
    $display("test fault done");
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    t_power_up();
    t_decode();
    t_shutdown();
    t_reset_pins();
    t_fault();
    end_of_test();
  end
  initial begin
    #1000000;
    mismatches++;
    end_of_test();
  end
endmodule

// ### src/cpsc_ctrl.sv
`timescale 1ns/100ps
module cpsc_ctrl (
  // Clock and power-up reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial link from host
  input wire logic ser_data,
  input wire logic ser_clk,
  input wire logic ser_latch,
  // Reset pins and mode
  input wire logic card_reset,
  input wire logic card_reset_n,
  input wire logic mode_indep,
  // Analog fault sense
  input wire logic [3:0] overcurrent,
  input wire logic overtemp,
  // Decoded selections
  output cpsc_pkg::cpsc_sel_t slot_a_card_supply,
  output cpsc_pkg::cpsc_sel_t slot_b_card_supply,
  output cpsc_pkg::cpsc_sel_t slot_a_prog_supply,
  output cpsc_pkg::cpsc_sel_t slot_b_prog_supply,
  output logic fault_flag_n
);
  logic [9:0] s;
  logic s_data, s_clk, s_latch, s_rst, s_rst_n, s_mode, s_ot;
  logic [3:0] s_ovc;
  logic clk_d, latch_d;
  logic [10:0] shreg, word;
  logic loaded;
  logic [10:0] next_shreg, next_word;
  logic next_loaded, next_clk_d, next_latch_d, next_fault_n;
  cpsc_pkg::cpsc_sel_t next_ac, next_bc, next_ap, next_bp;
  logic in_reset, clk_rise, latch_rise;

  cpsc_sync #(.W(10)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({ser_data, ser_clk, ser_latch, card_reset, card_reset_n, mode_indep, overtemp, overcurrent[2:0]}),
    .q(s)
  );
  assign {s_data, s_clk, s_latch, s_rst, s_rst_n, s_mode, s_ot} = s[9:3];
  cpsc_sync #(.W(1)) u_sync_ovc3 (
    .clk(clk),
    .rst_n(rst_n),
    .d(overcurrent[3]),
    .q(s_ovc[3])
  );
  assign s_ovc[2:0] = s[2:0];

  function automatic cpsc_pkg::cpsc_sel_t vcc_dec(input logic hi, input logic lo);
    case ({hi, lo})
      2'h1: vcc_dec = cpsc_pkg::CPSC_V33;
      2'h2: vcc_dec = cpsc_pkg::CPSC_V5;
      default: vcc_dec = cpsc_pkg::CPSC_ZERO;
    endcase
  endfunction

  function automatic cpsc_pkg::cpsc_sel_t vpp_dec(input logic b0, input logic b1, input logic x,
                                                  input logic ind, input cpsc_pkg::cpsc_sel_t vcc);
    case ({b0, b1})
      2'h0: vpp_dec = cpsc_pkg::CPSC_ZERO;
      2'h1: vpp_dec = ind ? (x ? cpsc_pkg::CPSC_V5 : cpsc_pkg::CPSC_V33) : vcc;
      2'h2: vpp_dec = cpsc_pkg::CPSC_V12;
      default: vpp_dec = cpsc_pkg::CPSC_HIZ;
    endcase
  endfunction

  // Mode pulldown: synced reset value 0 gives dependent decode
  assign in_reset = s_rst | ~s_rst_n | ~rst_n;
  assign clk_rise = s_clk & ~clk_d;
  assign latch_rise = s_latch & ~latch_d;

  always_comb begin
    cpsc_pkg::cpsc_sel_t ac, bc;
    ac = vcc_dec(word[cpsc_pkg::B_VCCA_HI], word[cpsc_pkg::B_VCCA_LO]);
    bc = vcc_dec(word[cpsc_pkg::B_VCCB_HI], word[cpsc_pkg::B_VCCB_LO]);
    next_clk_d = s_clk;
    next_latch_d = s_latch;
    next_shreg = shreg;
    next_word = word;
    next_loaded = loaded;
    if (clk_rise) begin
      next_shreg = {shreg[9:0], s_data};
    end
    if (in_reset) begin
      next_loaded = 1'b0;
    end else if (latch_rise) begin
      next_word = shreg;
      next_loaded = 1'b1;
    end
    next_ac = ac;
    next_bc = bc;
    next_ap = vpp_dec(word[cpsc_pkg::B_VPPA0], word[cpsc_pkg::B_VPPA1], word[cpsc_pkg::B_XA], s_mode, ac);
    next_bp = vpp_dec(word[cpsc_pkg::B_VPPB0], word[cpsc_pkg::B_VPPB1], word[cpsc_pkg::B_XB], s_mode, bc);
    if (!word[cpsc_pkg::B_ON_N]) begin
      next_ac = cpsc_pkg::CPSC_HIZ;
      next_bc = cpsc_pkg::CPSC_HIZ;
      next_ap = cpsc_pkg::CPSC_HIZ;
      next_bp = cpsc_pkg::CPSC_HIZ;
    end
    if (in_reset || !loaded) begin
      next_ac = cpsc_pkg::CPSC_GND;
      next_bc = cpsc_pkg::CPSC_GND;
      next_ap = cpsc_pkg::CPSC_GND;
      next_bp = cpsc_pkg::CPSC_GND;
    end
    next_fault_n = ~(|s_ovc | s_ot);
  end

  // Selections update one cycle after load; switch sequencing is analog
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_d <= 1'b0;
      latch_d <= 1'b0;
      shreg <= cpsc_pkg::WORD_RST;
      word <= cpsc_pkg::WORD_RST;
      loaded <= 1'b0;
      slot_a_card_supply <= cpsc_pkg::CPSC_GND;
      slot_b_card_supply <= cpsc_pkg::CPSC_GND;
      slot_a_prog_supply <= cpsc_pkg::CPSC_GND;
      slot_b_prog_supply <= cpsc_pkg::CPSC_GND;
      fault_flag_n <= 1'b1;
    end else begin
      clk_d <= next_clk_d;
      latch_d <= next_latch_d;
      shreg <= next_shreg;
      word <= next_word;
      loaded <= next_loaded;
      slot_a_card_supply <= next_ac;
      slot_b_card_supply <= next_bc;
      slot_a_prog_supply <= next_ap;
      slot_b_prog_supply <= next_bp;
      fault_flag_n <= next_fault_n;
    end
  end

  property p_reset_ground;
    @(posedge clk) disable iff (!rst_n) in_reset |=> slot_a_card_supply == cpsc_pkg::CPSC_GND
      && slot_b_card_supply == cpsc_pkg::CPSC_GND && slot_a_prog_supply == cpsc_pkg::CPSC_GND
      && slot_b_prog_supply == cpsc_pkg::CPSC_GND;
  endproperty
  a_reset_ground: assert property (p_reset_ground) else $error("outputs not grounded in reset");

  property p_load;
    @(posedge clk) disable iff (!rst_n) (latch_rise && !in_reset) |=> word == $past(shreg);
  endproperty
  a_load: assert property (p_load) else $error("word not loaded on latch");

  property p_shift;
    @(posedge clk) disable iff (!rst_n) clk_rise |=> shreg[0] == $past(s_data);
  endproperty
  a_shift: assert property (p_shift) else $error("data bit not shifted");

  property p_no_load_reset;
    @(posedge clk) disable iff (!rst_n) in_reset |=> !loaded;
  endproperty
  a_no_load_reset: assert property (p_no_load_reset) else $error("load during reset");

  property p_hold_ground;
    @(posedge clk) disable iff (!rst_n) !loaded |=> slot_b_card_supply == cpsc_pkg::CPSC_GND;
  endproperty
  a_hold_ground: assert property (p_hold_ground) else $error("left ground before load");

  property p_shutdown;
    @(posedge clk) disable iff (!rst_n) (loaded && !in_reset && !word[cpsc_pkg::B_ON_N])
      |=> slot_a_prog_supply == cpsc_pkg::CPSC_HIZ;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown not high impedance");

  property p_fault;
    @(posedge clk) disable iff (!rst_n) (|s_ovc || s_ot) |=> !fault_flag_n;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not flagged");

  property p_fault_clear;
    @(posedge clk) disable iff (!rst_n) !(|s_ovc || s_ot) |=> fault_flag_n;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault flag stuck low");

  property p_vcc_decode;
    @(posedge clk) disable iff (!rst_n) (loaded && !in_reset && word[cpsc_pkg::B_ON_N]
      && word[cpsc_pkg::B_VCCA_HI] && !word[cpsc_pkg::B_VCCA_LO]) |=> slot_a_card_supply == cpsc_pkg::CPSC_V5;
  endproperty
  a_vcc_decode: assert property (p_vcc_decode) else $error("slot A VCC 5V decode wrong");

  property p_reset_pins;
    @(posedge clk) disable iff (!rst_n) (s_rst || !s_rst_n) |=> slot_b_prog_supply == cpsc_pkg::CPSC_GND
      && slot_a_prog_supply == cpsc_pkg::CPSC_GND;
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("reset pin did not ground outputs");

  property p_shift_order;
    @(posedge clk) disable iff (!rst_n) clk_rise |=> shreg[10:1] == $past(shreg[9:0]);
  endproperty
  a_shift_order: assert property (p_shift_order) else $error("shift order broken");

  property p_vpp_indep;
    @(posedge clk) disable iff (!rst_n) (loaded && !in_reset && word[cpsc_pkg::B_ON_N] && s_mode
      && !word[cpsc_pkg::B_VPPB0] && word[cpsc_pkg::B_VPPB1] && word[cpsc_pkg::B_XB])
      |=> slot_b_prog_supply == cpsc_pkg::CPSC_V5;
  endproperty
  a_vpp_indep: assert property (p_vpp_indep) else $error("slot B VPP 5V decode wrong");

  property p_vpp_follow;
    @(posedge clk) disable iff (!rst_n) (loaded && !in_reset && word[cpsc_pkg::B_ON_N] && !s_mode
      && !word[cpsc_pkg::B_VPPA0] && word[cpsc_pkg::B_VPPA1]) |=> slot_a_prog_supply == slot_a_card_supply;
  endproperty
  a_vpp_follow: assert property (p_vpp_follow) else $error("slot A VPP does not follow VCC");

  property p_vpp_12;
    @(posedge clk) disable iff (!rst_n) (loaded && !in_reset && word[cpsc_pkg::B_ON_N]
      && word[cpsc_pkg::B_VPPA0] && !word[cpsc_pkg::B_VPPA1]) |=> slot_a_prog_supply == cpsc_pkg::CPSC_V12;
  endproperty
  a_vpp_12: assert property (p_vpp_12) else $error("slot A VPP 12V decode wrong");

  property p_vcc_b;
    @(posedge clk) disable iff (!rst_n) (loaded && !in_reset && word[cpsc_pkg::B_ON_N]
      && !word[cpsc_pkg::B_VCCB_HI] && word[cpsc_pkg::B_VCCB_LO]) |=> slot_b_card_supply == cpsc_pkg::CPSC_V33;
  endproperty
  a_vcc_b: assert property (p_vcc_b) else $error("slot B VCC 3.3V decode wrong");

  property p_vcc_zero;
    @(posedge clk) disable iff (!rst_n) (loaded && !in_reset && word[cpsc_pkg::B_ON_N]
      && word[cpsc_pkg::B_VCCA_HI] && word[cpsc_pkg::B_VCCA_LO]) |=> slot_a_card_supply == cpsc_pkg::CPSC_ZERO;
  endproperty
  a_vcc_zero: assert property (p_vcc_zero) else $error("slot A VCC code 11 not zero volts");

  c_load: cover property (@(posedge clk) disable iff (!rst_n) latch_rise && !in_reset);
  c_reset_latch: cover property (@(posedge clk) disable iff (!rst_n) latch_rise && in_reset);
  c_v12: cover property (@(posedge clk) disable iff (!rst_n) slot_b_prog_supply == cpsc_pkg::CPSC_V12);
  c_shutdown: cover property (@(posedge clk) disable iff (!rst_n) slot_a_card_supply == cpsc_pkg::CPSC_HIZ);
  c_fault: cover property (@(posedge clk) disable iff (!rst_n) !fault_flag_n);
endmodule

// ### src/cpsc_pkg.sv
// Contract
// - Sample serial data on each link clock rise
// - Latch strobe rise loads eleven bits D0..D10
// - Reset grounds all four supply outputs
// - Grounded state holds until a fresh load
// - Latch edges ignored while reset asserted
// - Active-high and active-low reset inputs both act
// - Power-up enters reset state automatically
// - Fault on any overcurrent or overtemperature
// - Mode high: VPP independent with extra bit
// - Mode low: VPP 01 follows slot VCC
// - VCC pair decode 00/11 0V, 01 3.3V, 10 5V
// - D8 low forces all four supply outputs high impedance
// - Mode input selects dependent or independent decode
// - Fault output active low
package cpsc_pkg;
  localparam int WORD_W = 11;
  // Bit positions in the control word
  localparam int B_VPPA0 = 0;
  localparam int B_VPPA1 = 1;
  localparam int B_VCCA_LO = 2;
  localparam int B_VCCA_HI = 3;
  localparam int B_VPPB0 = 4;
  localparam int B_VPPB1 = 5;
  localparam int B_VCCB_HI = 6;
  localparam int B_VCCB_LO = 7;
  localparam int B_ON_N = 8;
  localparam int B_XA = 9;
  localparam int B_XB = 10;
  localparam logic [10:0] WORD_RST = 11'h000;
  // Output selection encoding
  typedef enum logic [2:0] {
    CPSC_GND = 3'h0,
    CPSC_V33 = 3'h1,
    CPSC_V5 = 3'h2,
    CPSC_V12 = 3'h3,
    CPSC_HIZ = 3'h4,
    CPSC_ZERO = 3'h5
  } cpsc_sel_t;
endpackage

// ### src/cpsc_sync.sv
`timescale 1ns/100ps
module cpsc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Async in, synced out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule
